// File: rtl/shw_pkg.sv
// Package: register map, field positions, reset values and states of the serial port
package shw_pkg;
  localparam int          ADDR_W     = 8;
  localparam int          DATA_W     = 32;
  localparam int          BYTE_W     = 8;
  // Register indices; byte address is four times the index
  localparam int          IDX_DATA   = 'h31;
  localparam int          IDX_CTRL   = 'h32;
  localparam int          IDX_CSR    = 'h33;
  localparam int          IDX_ISTAT  = 'h38;
  localparam int          IDX_IMASK  = 'h39;
  localparam logic [7:0]  ADDR_DATA  = 8'(IDX_DATA * 4);
  localparam logic [7:0]  ADDR_CTRL  = 8'(IDX_CTRL * 4);
  localparam logic [7:0]  ADDR_CSR   = 8'(IDX_CSR * 4);
  localparam logic [7:0]  ADDR_ISTAT = 8'(IDX_ISTAT * 4);
  localparam logic [7:0]  ADDR_IMASK = 8'(IDX_IMASK * 4);
  // Control register fields
  localparam int          CR_IE      = 7;
  localparam int          CR_EN      = 6;
  localparam int          CR_R2      = 5;
  localparam int          CR_MS      = 4;
  localparam int          CR_POL     = 3;
  localparam int          CR_PHA     = 2;
  localparam int          CR_R1      = 1;
  localparam int          CR_R0      = 0;
  // Control/status register fields
  localparam int          CS_DONE    = 7;
  localparam int          CS_WRITE_COLLISION_FLAG    = 6;
  localparam int          CS_OVR     = 5;
  localparam int          CS_FAULT   = 4;
  localparam int          CS_OD      = 2;
  localparam int          CS_SSM     = 1;
  localparam int          CS_SSI     = 0;
  // Interrupt status and mask fields
  localparam int          IS_DONE    = 0;
  localparam int          IS_FAULT   = 1;
  localparam int          IS_OVR     = 2;
  localparam int          IS_RECOV   = 7;
  localparam int          IS_W       = 3;
  // Reset values
  localparam logic [7:0]  CTRL_RST   = 8'h00;
  localparam logic [7:0]  DATA_RST   = 8'h00;
  localparam logic [2:0]  IMASK_RST  = 3'h7;
  // Link timing
  localparam int          HALF_BASE  = 2;
  localparam logic [4:0]  HALF_LAST  = 5'h10;
  localparam logic [3:0]  BIT_LAST   = 4'h7;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SLAVE  = 3'b010,
    ST_MASTER = 3'b100
  } shw_state_t;
endpackage : shw_pkg

// File: rtl/shw_pin_sync.sv
// Two-flop synchroniser for link pins with edge detection on bit 0
`timescale 1ns/1ps
module shw_pin_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pinIn,
  output logic      [WIDTH-1:0] pinSync,
  output logic                  rise,
  output logic                  fall
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
    logic             prev;
  } shw_sync_t;

  shw_sync_t s_q;
  shw_sync_t s_d;

  always_comb
  begin
    s_d      = s_q;
    s_d.meta = pinIn;
    s_d.sync = s_q.meta;
    s_d.prev = s_q.sync[0];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Edges only from the settled stage, never from the first flop
  assign pinSync = s_q.sync;
  assign rise    = s_q.sync[0] & ~s_q.prev;
  assign fall    = ~s_q.sync[0] & s_q.prev;
endmodule : shw_pin_sync

// File: rtl/shw_serial_port.sv
// Serial port with halt wake-up, shared interrupt and APB register file
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module shw_serial_port
  import shw_pkg::*;
#(
  parameter int HALF_BASE_P = HALF_BASE
) (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cpuHalt,
  input  wire logic              cpuIntMask,
  input  wire logic              sckIn,
  input  wire logic              mosiIn,
  input  wire logic              misoIn,
  input  wire logic              selectInN,
  output logic                   sckOut,
  output logic                   sckOeN,
  output logic                   mosiOut,
  output logic                   mosiOeN,
  output logic                   misoOut,
  output logic                   misoOeN,
  output logic                   irq,
  output logic                   haltWake,
  output logic                   waitWake
);
  typedef struct packed {
    shw_state_t       state;
    logic [7:0]       ctrl;
    logic             odis;
    logic             select_by_software;
    logic             soft_select_level;
    logic             done;
    logic             write_collision_flag;
    logic             overrun_flag;
    logic             fault;
    logic             doneSeen;
    logic             wcolSeen;
    logic             faultSeen;
    logic [7:0]       rxBuf;
    logic [7:0]       rxShift;
    logic [7:0]       txShift;
    logic [3:0]       bitCnt;
    logic [4:0]       halfCnt;
    logic [9:0]       divCnt;
    logic             sck;
    logic [IS_W-1:0]  istat;
    logic [IS_W-1:0]  imask;
    logic             haltPrev;
    logic             haltArm;
    logic             haltWoke;
    logic             recover;
    logic             ready;
    logic [7:0]       rdata;
    logic             err;
  } shw_regs_t;

  shw_regs_t r_q;
  shw_regs_t r_d;

  logic [3:0] pinSync;
  logic       sckRise;
  logic       sckFall;

  shw_pin_sync #(
    .WIDTH (4)
  ) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .pinIn    ({selectInN, misoIn, mosiIn, sckIn}),
    .pinSync  (pinSync),
    .rise     (sckRise),
    .fall     (sckFall)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Combinational helpers
  logic       selLow;
  logic       isMaster;
  logic       enabled;
  logic       access;
  logic       wrAcc;
  logic       rdAcc;
  logic       mapped;
  logic [2:0] rate;
  logic [9:0] halfLim;
  logic       linkEdge;
  logic [4:0] hNew;
  logic       isSample;
  logic       isShift;
  logic       din;
  logic [7:0] byteIn;
  logic       wrLive;

  always_comb
  begin
    selLow   = r_q.select_by_software ? ~r_q.soft_select_level : ~pinSync[3];
    isMaster = r_q.ctrl[CR_MS];
    enabled  = r_q.ctrl[CR_EN];
    rate     = {r_q.ctrl[CR_R2], r_q.ctrl[CR_R1], r_q.ctrl[CR_R0]};
    halfLim  = 10'((HALF_BASE_P << rate) - 1);
    mapped   = (paddr == ADDR_DATA) || (paddr == ADDR_CTRL) || (paddr == ADDR_CSR)
            || (paddr == ADDR_ISTAT) || (paddr == ADDR_IMASK);
    // Registers frozen in halt: no bus side effects
    access   = psel & penable & r_q.ready & mapped & ~cpuHalt;
    wrAcc    = access & pwrite;
    rdAcc    = access & ~pwrite;
    wrLive   = wrAcc;
    linkEdge = (r_q.state == ST_MASTER) ? (r_q.divCnt == halfLim)
             : (enabled & ~isMaster & selLow & (sckRise | sckFall));
    hNew     = (r_q.state == ST_IDLE) ? 5'h01 : r_q.halfCnt + 5'h01;
    isSample = hNew[0] ^ r_q.ctrl[CR_PHA];
    isShift  = ~isSample & (hNew != 5'h01);
    din      = (r_q.state == ST_MASTER) ? pinSync[2] : pinSync[1];
    byteIn   = {r_q.rxShift[6:0], din};
  end

  //////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    r_d       = r_q;
    r_d.ready = psel & penable & ~r_q.ready;
    if (psel & penable & ~r_q.ready)
    begin
      r_d.err = ~mapped;
      unique case (paddr)
        ADDR_DATA:  r_d.rdata = r_q.rxBuf;
        ADDR_CTRL:  r_d.rdata = r_q.ctrl;
        ADDR_CSR:   r_d.rdata = {r_q.done, r_q.write_collision_flag, r_q.overrun_flag, r_q.fault, 1'b0, r_q.odis, r_q.select_by_software, r_q.soft_select_level};
        ADDR_ISTAT: r_d.rdata = {r_q.recover, 4'h0, r_q.istat};
        ADDR_IMASK: r_d.rdata = {5'h00, r_q.imask};
        default:    r_d.rdata = 8'h00;
      endcase
    end

    // Bus side: clears first so that hardware sets below win
    if (rdAcc && paddr == ADDR_CSR)
    begin
      r_d.overrun_flag       = 1'b0;
      r_d.doneSeen  = r_q.done;
      r_d.wcolSeen  = r_q.write_collision_flag;
      r_d.faultSeen = r_q.fault;
    end
    if (access && paddr == ADDR_DATA)
    begin
      if (r_q.doneSeen)
      begin
        r_d.done     = 1'b0;
        r_d.doneSeen = 1'b0;
      end
      if (r_q.wcolSeen)
      begin
        r_d.write_collision_flag     = 1'b0;
        r_d.wcolSeen = 1'b0;
      end
    end
    if (wrLive && paddr == ADDR_DATA)
    begin
      if (r_q.state != ST_IDLE)
      begin
        r_d.write_collision_flag = 1'b1;
      end
      else
      begin
        r_d.txShift = pwdata[7:0];
        if (isMaster & enabled)
        begin
          r_d.state   = ST_MASTER;
          r_d.divCnt  = 10'h000;
          r_d.halfCnt = 5'h00;
          r_d.bitCnt  = 4'h0;
        end
      end
    end
    if (wrLive && paddr == ADDR_CTRL)
    begin
      r_d.ctrl = pwdata[7:0];
      if (r_q.fault & r_q.faultSeen)
      begin
        r_d.fault     = 1'b0;
        r_d.faultSeen = 1'b0;
      end
      else if (r_q.fault)
      begin
        // Enable and master select stay low until the clearing sequence
        r_d.ctrl[CR_EN] = 1'b0;
        r_d.ctrl[CR_MS] = 1'b0;
      end
    end
    if (wrLive && paddr == ADDR_CSR)
    begin
      r_d.odis = pwdata[CS_OD];
      r_d.select_by_software  = pwdata[CS_SSM];
      r_d.soft_select_level  = pwdata[CS_SSI];
    end
    if (wrLive && paddr == ADDR_ISTAT)
    begin
      r_d.istat = r_q.istat & ~pwdata[IS_W-1:0];
    end
    if (wrLive && paddr == ADDR_IMASK)
    begin
      r_d.imask = pwdata[IS_W-1:0];
    end

    // Link side; the shifter keeps running during halt
    unique case (r_q.state)
      ST_IDLE:
      begin
        r_d.sck = r_q.ctrl[CR_POL];
        if (linkEdge)
        begin
          r_d.state   = ST_SLAVE;
          r_d.halfCnt = 5'h00;
          r_d.bitCnt  = 4'h0;
        end
      end
      ST_SLAVE:
      begin
        // Deselect aborts a partial byte
        if (~selLow | isMaster | ~enabled)
        begin
          r_d.state   = ST_IDLE;
          r_d.halfCnt = 5'h00;
          r_d.bitCnt  = 4'h0;
        end
      end
      ST_MASTER:
      begin
        r_d.divCnt = linkEdge ? 10'h000 : r_q.divCnt + 10'h001;
        if (linkEdge)
        begin
          r_d.sck = ~r_q.sck;
          if (hNew == HALF_LAST)
          begin
            r_d.state = ST_IDLE;
          end
        end
      end
      default:
      begin
        r_d.state = ST_IDLE;
      end
    endcase

    if (linkEdge && ((r_q.state == ST_MASTER) || (r_d.state == ST_SLAVE)))
    begin
      r_d.halfCnt = hNew;
      if (isShift && r_q.state != ST_IDLE)
      begin
        r_d.txShift = {r_q.txShift[6:0], 1'b0};
      end
      if (isSample)
      begin
        r_d.rxShift = byteIn;
        r_d.bitCnt  = r_q.bitCnt + 4'h1;
        if (r_q.bitCnt == BIT_LAST)
        begin
          // Restart the count so a held select can carry the next byte
          r_d.bitCnt = 4'h0;
          if (r_q.recover)
          begin
            r_d.recover = 1'b0;
          end
          else if (~r_q.done)
          begin
            r_d.done          = 1'b1;
            r_d.rxBuf         = byteIn;
            r_d.istat[IS_DONE] = 1'b1;
          end
          else
          begin
            r_d.overrun_flag           = 1'b1;
            r_d.istat[IS_OVR] = 1'b1;
          end
        end
      end
    end

    // Mode fault takes the port out of master mode
    if (isMaster & enabled & selLow)
    begin
      r_d.fault           = 1'b1;
      r_d.ctrl[CR_EN]     = 1'b0;
      r_d.ctrl[CR_MS]     = 1'b0;
      r_d.state           = ST_IDLE;
      r_d.istat[IS_FAULT] = 1'b1;
    end

    // Halt entry, wake and exit
    r_d.haltPrev = cpuHalt;
    if (cpuHalt & ~r_q.haltPrev)
    begin
      r_d.haltArm  = selLow;
      r_d.haltWoke = 1'b0;
    end
    if (haltWake)
    begin
      r_d.haltWoke = 1'b1;
    end
    if (~cpuHalt & r_q.haltPrev)
    begin
      r_d.haltArm  = 1'b0;
      r_d.haltWoke = 1'b0;
      r_d.recover  = r_q.haltWoke & ~r_d.ctrl[CR_MS];
    end
    // Master mode or disable ends the recovery state at once
    r_d.recover = r_d.recover & r_d.ctrl[CR_EN] & ~r_d.ctrl[CR_MS];
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      r_q       <= '0;
      r_q.state <= ST_IDLE;
      r_q.ctrl  <= CTRL_RST;
      r_q.rxBuf <= DATA_RST;
      r_q.imask <= IMASK_RST;
    end
    else
    begin
      r_q <= r_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  logic pending;
  // Write collision has no path into the interrupt status
  assign pending  = r_q.ctrl[CR_IE] & |(r_q.istat & r_q.imask);
  assign irq      = pending & ~cpuIntMask;
  assign waitWake = pending;
  // Only a done event wakes from halt, never a fault
  assign haltWake = cpuHalt & r_q.haltArm & r_q.done & r_q.ctrl[CR_IE] & ~r_q.ctrl[CR_MS];
  assign prdata   = {24'h000000, r_q.rdata};
  assign pready   = r_q.ready;
  assign pslverr  = r_q.ready & r_q.err;
  assign sckOut   = r_q.sck;
  assign mosiOut  = r_q.txShift[7];
  assign misoOut  = r_q.txShift[7];
  assign sckOeN   = ~(r_q.ctrl[CR_EN] & r_q.ctrl[CR_MS] & ~r_q.odis);
  assign mosiOeN  = ~(r_q.ctrl[CR_EN] & r_q.ctrl[CR_MS] & ~r_q.odis);
  assign misoOeN  = ~(r_q.ctrl[CR_EN] & ~r_q.ctrl[CR_MS] & selLow & ~r_q.odis);
endmodule : shw_serial_port

// File: test/shw_serial_port_monitor.sv
// Checker: port-level relations of the serial port
`timescale 1ns/1ps
module shw_serial_port_monitor import shw_pkg::*; (
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              cpuHalt,
  input wire logic              cpuIntMask,
  input wire logic              sckOeN,
  input wire logic              misoOeN,
  input wire logic              irq,
  input wire logic              haltWake,
  input wire logic              waitWake
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_rdy2; psel && !penable |-> !pready ##1 !pready ##1 pready; endproperty
  a_rdy2: assert property (p_rdy2) else $error("pready not in second access cycle");
  property p_rdy1; pready |=> !pready; endproperty
  a_rdy1: assert property (p_rdy1) else $error("pready held too long");
  property p_rdyacc; pready |-> psel && penable; endproperty
  a_rdyacc: assert property (p_rdyacc) else $error("pready outside access");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  a_hi: assert property (p_hi) else $error("upper read data not zero");
  property p_irq; irq |-> waitWake && !cpuIntMask; endproperty
  a_irq: assert property (p_irq) else $error("irq without cause or while masked");
  property p_irqon; waitWake && !cpuIntMask && !$past(cpuIntMask) |-> irq; endproperty
  a_irqon: assert property (p_irqon) else $error("irq missing");
  property p_wake; haltWake |-> cpuHalt && sckOeN; endproperty
  a_wake: assert property (p_wake) else $error("wake outside halt or as master");
  property p_oe; !misoOeN |-> sckOeN; endproperty
  a_oe: assert property (p_oe) else $error("master and slave drive at once");
  property p_rst; @(posedge core_clk) disable iff (1'b0) rst |=> !irq && !pready; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule : shw_serial_port_monitor
bind shw_serial_port shw_serial_port_monitor i_mon (.core_clk(core_clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata), .cpuHalt(cpuHalt),
  .cpuIntMask(cpuIntMask), .sckOeN(sckOeN), .misoOeN(misoOeN), .irq(irq), .haltWake(haltWake),
  .waitWake(waitWake));

// File: test/shw_spi_master_model.sv
// Partner: external serial master, mode 0, 160 ns link clock
`timescale 1ns/1ps
module shw_spi_master_model (
  input wire logic core_clk,
  input wire logic miso,
  output logic     sck,
  output logic     mosi,
  output logic     ssN
);
  initial
  begin
    sck = 0;
    mosi = 0;
    ssN = 1;
  end
  // Sixteen core cycles is one half period of the link clock
  task automatic half();
    repeat (16) @(posedge core_clk);
  endtask : half
  task automatic select(input logic lvl);
    @(posedge core_clk);
    ssN <= lvl;
  endtask : select
  // Select stays low afterwards so halt entry can be armed; ends with one idle half period and a mosi toggle
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    @(posedge core_clk);
    ssN <= 0;
    for (int i = 7; i >= 0; i--)
    begin
      mosi <= tx[i];
      half();
      sck <= 1;
      rx[i] = miso;
      half();
      sck <= 0;
    end
    half();
    mosi <= ~mosi;
  endtask : xfer
endmodule : shw_spi_master_model

// File: test/shw_serial_port_tb.sv
// Testbench: registers, slave transfers, halt wake-up, faults and interrupts
`timescale 1ns/1ps
module shw_serial_port_tb import shw_pkg::*; ();
  logic core_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, cpuHalt = 0, cpuIntMask = 0, tog = 0;
  logic [ADDR_W-1:0] paddr = 0;
  logic [DATA_W-1:0] pwdata = 0, prdata;
  logic pready, pslverr, sckOut, sckOeN, mosiOut, mosiOeN, misoOut, misoOeN, irq, haltWake, waitWake;
  logic mSck, mMosi, mSsN, er;
  logic [7:0] v, rx, t, b;
  logic [31:0] seed = 32'he16a;
  int bad_count = 0, comparisons = 0;
  // A released miso line shows a changing pattern, never a held value; released sck and mosi follow the model
  wire logic sckW = sckOeN ? mSck : sckOut;
  wire logic mosiW = mosiOeN ? mMosi : mosiOut;
  wire logic misoW = misoOeN ? tog : misoOut;
  initial forever #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) tog <= ~tog;
  shw_serial_port i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpuHalt, .cpuIntMask, .sckIn(sckW), .mosiIn(mosiW), .misoIn(misoW), .selectInN(mSsN),
    .sckOut, .sckOeN, .mosiOut, .mosiOeN, .misoOut, .misoOeN, .irq, .haltWake, .waitWake);
  shw_spi_master_model i_mdl (.core_clk(core_clk), .miso(misoW), .sck(mSck), .mosi(mMosi), .ssN(mSsN));
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  function automatic logic [7:0] csrE(input logic d, input logic w, input logic o, input logic f);
    return ({7'h0, d} << CS_DONE) | ({7'h0, w} << CS_WRITE_COLLISION_FLAG) | ({7'h0, o} << CS_OVR) | ({7'h0, f} << CS_FAULT);
  endfunction : csrE
  function automatic logic [7:0] isE(input logic r, input logic o, input logic f, input logic d);
    return ({7'h0, r} << IS_RECOV) | ({7'h0, o} << IS_OVR) | ({7'h0, f} << IS_FAULT) | ({7'h0, d} << IS_DONE);
  endfunction : isE
  task automatic complete_run();
    if (bad_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask : tick
  // One APB transfer; the answer is taken only at the edge with pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      complete_run();
    end
    v = prdata[7:0];
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rc(input string nm, input logic [7:0] a, input logic [7:0] e);
    apb(0, a, 8'h00);
    chk(nm, e, v);
  endtask : rc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1, a, d);
  endtask : wr
  task automatic halt_round(input logic armed, input logic leave);
    i_mdl.select(!armed);
    tick(6);
    cpuHalt <= 1;
    tick(2);
    seed = xs(seed);
    i_mdl.xfer(seed[7:0], rx);
    chk("haltWake", armed, haltWake);
    wr(ADDR_CTRL, 8'h00);
    cpuHalt <= 0;
    tick(2);
    rc("ctrl frozen", ADDR_CTRL, 8'hc0);
    rc("istat halt", ADDR_ISTAT, isE(armed, 0, 0, 1));
    rc("csr halt", ADDR_CSR, csrE(1, 0, 0, 0));
    rc("data halt", ADDR_DATA, seed[7:0]);
    wr(ADDR_ISTAT, 8'h07);
    if (leave)
    begin
      i_mdl.select(1);
      tick(6);
      wr(ADDR_CTRL, 8'hd0);
      rc("recovery", ADDR_ISTAT, 8'h00);
      wr(ADDR_CTRL, 8'hc0);
    end
    else if (armed)
    begin
      i_mdl.xfer(~seed[7:0], rx);
      rc("dummy flags", ADDR_ISTAT, 8'h00);
      rc("dummy data", ADDR_DATA, seed[7:0]);
    end
  endtask : halt_round
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    tick(3);
    rst <= 0;
    tick(4);
    rc("ctrl rst", ADDR_CTRL, CTRL_RST);
    rc("csr rst", ADDR_CSR, 8'h00);
    rc("imask rst", ADDR_IMASK, 8'(IMASK_RST));
    rc("istat rst", ADDR_ISTAT, 8'h00);
    rc("data rst", ADDR_DATA, DATA_RST);
    rc("unmapped", 8'h00, 8'h00);
    chk("pslverr", 1, er);
    wr(ADDR_CTRL, 8'hc0);
    seed = xs(seed);
    t = seed[7:0];
    b = seed[15:8];
    wr(ADDR_DATA, t);
    i_mdl.xfer(b, rx);
    chk("slave tx", t, rx);
    tick(2);
    chk("irq done", 1, irq);
    cpuIntMask <= 1;
    tick(2);
    chk("irq global mask", 0, irq);
    chk("waitWake", 1, waitWake);
    cpuIntMask <= 0;
    wr(ADDR_IMASK, 8'h00);
    tick(2);
    chk("irq imask", 0, irq);
    wr(ADDR_IMASK, 8'h07);
    wr(ADDR_CTRL, 8'h40);
    tick(2);
    chk("irq enable off", 0, irq);
    wr(ADDR_CTRL, 8'hc0);
    i_mdl.xfer(~b, rx);
    rc("csr overrun", ADDR_CSR, csrE(1, 0, 1, 0));
    rc("data first", ADDR_DATA, b);
    rc("csr cleared", ADDR_CSR, 8'h00);
    rc("istat overrun", ADDR_ISTAT, isE(0, 1, 0, 1));
    wr(ADDR_ISTAT, 8'h07);
    fork
      i_mdl.xfer(b, rx);
      begin
        tick(60);
        wr(ADDR_DATA, 8'h5a);
        tick(2);
        chk("irq write_collision_flag", 0, irq);
      end
    join
    rc("csr write_collision_flag", ADDR_CSR, csrE(1, 1, 0, 0));
    rc("data write_collision_flag", ADDR_DATA, b);
    wr(ADDR_ISTAT, 8'h07);
    halt_round(1, 0);
    halt_round(0, 0);
    halt_round(1, 1);
    wr(ADDR_CTRL, 8'hd4);
    seed = xs(seed);
    wr(ADDR_DATA, seed[7:0]);
    chk("sckOeN master", 0, sckOeN);
    tick(40);
    rc("csr master", ADDR_CSR, csrE(1, 0, 0, 0));
    apb(0, ADDR_DATA, 8'h00);
    rc("istat master", ADDR_ISTAT, isE(0, 0, 0, 1));
    wr(ADDR_ISTAT, 8'h07);
    rc("csr master clr", ADDR_CSR, 8'h00);
    wr(ADDR_CTRL, 8'hd0);
    i_mdl.select(0);
    tick(8);
    rc("ctrl fault", ADDR_CTRL, 8'h80);
    rc("csr fault", ADDR_CSR, csrE(0, 0, 0, 1));
    chk("irq fault", 1, irq);
    rc("istat fault", ADDR_ISTAT, isE(0, 0, 1, 0));
    complete_run();
  end
endmodule : shw_serial_port_tb
